// ==== rtl/lmr_pkg.sv ====
// Constants, register map and types for the load model and relaxation control block
package lmr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int SEL_W = 3;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DSG_THR = 8'h08;
  localparam logic [7:0] OFS_CHG_THR = 8'h0c;
  localparam logic [7:0] OFS_QUIT_CUR = 8'h10;
  localparam logic [7:0] OFS_DSG_RELAX = 8'h14;
  localparam logic [7:0] OFS_CHG_RELAX = 8'h18;
  localparam logic [7:0] OFS_QUIT_RELAX = 8'h1c;
  localparam logic [7:0] OFS_USER_I_RATE = 8'h20;
  localparam logic [7:0] OFS_USER_P_RATE = 8'h24;
  localparam logic [7:0] OFS_CHG_RESERVE = 8'h28;
  localparam logic [7:0] OFS_ENG_RESERVE = 8'h2c;
  localparam logic [7:0] OFS_QMAX_A = 8'h30;
  localparam logic [7:0] OFS_QMAX_B = 8'h34;
  localparam logic [7:0] OFS_LEARN_A = 8'h38;
  localparam logic [7:0] OFS_LEARN_B = 8'h3c;
  localparam logic [7:0] OFS_RATE = 8'h40;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int ST_MODE_BIT = 0;
  localparam int ST_DSG_BIT = 1;
  localparam int ST_CHG_BIT = 2;
  localparam int ST_RELAX_BIT = 3;
  localparam int ST_OCV_BIT = 4;
  localparam int ST_QMAX_OK_BIT = 5;
  localparam int LEARN_BIT = 0;
  localparam logic RST_LOAD_MODE = 1'b0;
  localparam logic [2:0] RST_LOAD_SEL = 3'h1;
  localparam logic [15:0] RST_DSG_THR = 16'h0064;
  localparam logic [15:0] RST_CHG_THR = 16'h0064;
  localparam logic [15:0] RST_QUIT_CUR = 16'h0028;
  localparam logic [12:0] RST_DSG_RELAX_S = 13'h003c;
  localparam logic [7:0] RST_CHG_RELAX_S = 8'h3c;
  localparam logic [5:0] RST_QUIT_RELAX_S = 6'h01;
  localparam logic [15:0] RST_QMAX = 16'h03e8;
  localparam logic [7:0] RST_LEARN = 8'h00;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_NS = 1000000000;
  localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int OCV_WAIT_MIN = 5;
  localparam logic [8:0] OCV_WAIT_S = 9'(OCV_WAIT_MIN * 60);
  localparam logic [15:0] SLOPE_LIMIT_UV = 16'h0004;
  localparam int LPF_TAU_S = 14;
  localparam int C_RATE_DIV = 5;
  localparam int PWR_SCALE = 10000;
  typedef enum logic [0:0] {
    LMR_ACTIVE = 1'b0,
    LMR_RELAX = 1'b1
  } lmr_relax_type;
endpackage

// ==== rtl/lmr_rate_if.sv ====
// Sources and selection for the load-compensation rate
`timescale 1ns/1ps
interface lmr_rate_if;
  logic load_mode;
  logic [lmr_pkg::SEL_W-1:0] load_select;
  logic signed [15:0] avg_i_last, avg_i_now, avg_i_filt, avg_i_lpf;
  logic signed [15:0] avg_p_last, avg_p_now, trial_rate;
  logic [15:0] cell_v, design_cap, design_energy, user_i_rate, user_p_rate;
  logic signed [15:0] rate;
  modport src (output load_mode, load_select, avg_i_last, avg_i_now, avg_i_filt, avg_i_lpf,
    avg_p_last, avg_p_now, trial_rate, cell_v, design_cap, design_energy, user_i_rate,
    user_p_rate, input rate);
  modport sel (input load_mode, load_select, avg_i_last, avg_i_now, avg_i_filt, avg_i_lpf,
    avg_p_last, avg_p_now, trial_rate, cell_v, design_cap, design_energy, user_i_rate,
    user_p_rate, output rate);
endinterface

// ==== rtl/lmr_timer.sv ====
// Whole-second condition timer that restarts whenever its condition drops
`timescale 1ns/1ps
module lmr_timer #(
  parameter int W = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] period,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire logic at_max = &cnt_q;

  // Saturates so a long quiet spell cannot wrap back below the period
  assign cnt_d = !run ? '0 : (tick && !at_max) ? cnt_q + 1'b1 : cnt_q;
  assign done = run && (cnt_q >= period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // lmr_timer

// ==== rtl/lmr_rate_sel.sv ====
// Picks the current or power rate that drives load compensation
`timescale 1ns/1ps
module lmr_rate_sel (
  lmr_rate_if.sel rif
);
  logic signed [31:0] p_filt;
  logic signed [31:0] p_lpf;
  logic signed [15:0] i_rate;
  logic signed [15:0] p_rate;

  // Current times millivolts gives microwatts; scale to 10 mW units
  assign p_filt = (32'(rif.avg_i_filt) * $signed({16'h0000, rif.cell_v})) / lmr_pkg::PWR_SCALE;
  assign p_lpf = (32'(rif.avg_i_lpf) * $signed({16'h0000, rif.cell_v})) / lmr_pkg::PWR_SCALE;

  always_comb begin
    unique case (rif.load_select)
      3'h0: i_rate = rif.avg_i_last;
      3'h1: i_rate = rif.avg_i_now;
      3'h2: i_rate = rif.avg_i_filt;
      3'h3: i_rate = rif.avg_i_lpf;
      3'h4: i_rate = $signed(16'(rif.design_cap / lmr_pkg::C_RATE_DIV));
      3'h5: i_rate = rif.trial_rate;
      3'h6: i_rate = $signed(rif.user_i_rate);
      default: i_rate = rif.avg_i_now;
    endcase
  end

  always_comb begin
    unique case (rif.load_select)
      3'h0: p_rate = rif.avg_p_last;
      3'h1: p_rate = rif.avg_p_now;
      3'h2: p_rate = p_filt[15:0];
      3'h3: p_rate = p_lpf[15:0];
      3'h4: p_rate = $signed(16'(rif.design_energy / lmr_pkg::C_RATE_DIV));
      3'h5: p_rate = rif.trial_rate;
      3'h6: p_rate = $signed(rif.user_p_rate);
      default: p_rate = rif.avg_p_now;
    endcase
  end

  assign rif.rate = rif.load_mode ? p_rate : i_rate;
endmodule // lmr_rate_sel

// ==== rtl/lmr_top.sv ====
// Load model selection, flow detection and relaxation control with APB registers
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module lmr_top #(
  parameter int SEC_CYCLES = lmr_pkg::SEC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lmr_pkg::ADDR_W-1:0] paddr,
  input wire logic [lmr_pkg::DATA_W-1:0] pwdata,
  output logic [lmr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] filtered_average_current,
  input wire logic signed [15:0] sense_current,
  input wire logic [15:0] cell_voltage,
  input wire logic signed [15:0] avg_i_last_run,
  input wire logic signed [15:0] avg_i_present,
  input wire logic signed [15:0] avg_p_last_run,
  input wire logic signed [15:0] avg_p_present,
  input wire logic [15:0] design_capacity,
  input wire logic [15:0] design_energy,
  input wire logic signed [15:0] trial_rate_value,
  input wire logic [15:0] voltage_slope_uv,
  input wire logic [15:0] qmax_new,
  input wire logic qmax_new_valid,
  input wire logic qmax_new_profile,
  output logic signed [15:0] load_rate,
  output logic load_model_flag,
  output logic dsg_flowing,
  output logic chg_flowing,
  output logic relax_active,
  output logic ocv_request,
  output logic qmax_update_ok,
  output logic [15:0] charge_reserve,
  output logic [15:0] energy_reserve
);
  if (SEC_CYCLES < 2) begin : g_bad_sec
    $error("SEC_CYCLES must be at least 2");
  end

  localparam int PW = $clog2(SEC_CYCLES);

  function automatic logic [15:0] lmr_mag(input logic signed [15:0] v);
    lmr_mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Configuration registers
  logic load_mode_q;
  logic [2:0] load_sel_q;
  logic [15:0] dsg_thr_q, chg_thr_q, quit_cur_q;
  logic [12:0] dsg_relax_q;
  logic [7:0] chg_relax_q;
  logic [5:0] quit_relax_q;
  logic [15:0] user_i_rate_q, user_p_rate_q, chg_res_q, eng_res_q;
  logic [15:0] qmax_a_q, qmax_b_q, qmax_a_d, qmax_b_d;
  logic [7:0] learn_a_q, learn_b_q, learn_a_d, learn_b_d;

  // Bus outputs
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  // Behaviour state
  logic [PW-1:0] pre_q;
  logic tick_q;
  logic signed [15:0] lpf_q;
  logic signed [16:0] lpf_step;
  lmr_pkg::lmr_relax_type state_q, state_d;
  logic last_chg_q;
  logic [8:0] relax_s_q;
  logic signed [15:0] rate_q;
  logic dsg_q, chg_q, ocv_q, qok_q;

  // Bus decode
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pwrite && pready_q && !pslverr_q;
  wire logic [7:0] a = paddr;
  wire logic wr_ctrl = wr_en && a == lmr_pkg::OFS_CTRL;
  wire logic wr_learn_a = wr_en && a == lmr_pkg::OFS_LEARN_A;
  wire logic wr_learn_b = wr_en && a == lmr_pkg::OFS_LEARN_B;
  wire logic wr_qmax_a = wr_en && a == lmr_pkg::OFS_QMAX_A;
  wire logic wr_qmax_b = wr_en && a == lmr_pkg::OFS_QMAX_B;

  // Status word seen by software and by the status outputs
  logic [31:0] status_w;
  assign status_w = 32'({qok_q, ocv_q, (state_q == lmr_pkg::LMR_RELAX), chg_q, dsg_q,
                         load_mode_q});

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (a)
      lmr_pkg::OFS_CTRL: rd_mux = 32'({load_sel_q, 3'h0, load_mode_q});
      lmr_pkg::OFS_STATUS: rd_mux = status_w;
      lmr_pkg::OFS_DSG_THR: rd_mux = 32'(dsg_thr_q);
      lmr_pkg::OFS_CHG_THR: rd_mux = 32'(chg_thr_q);
      lmr_pkg::OFS_QUIT_CUR: rd_mux = 32'(quit_cur_q);
      lmr_pkg::OFS_DSG_RELAX: rd_mux = 32'(dsg_relax_q);
      lmr_pkg::OFS_CHG_RELAX: rd_mux = 32'(chg_relax_q);
      lmr_pkg::OFS_QUIT_RELAX: rd_mux = 32'(quit_relax_q);
      lmr_pkg::OFS_USER_I_RATE: rd_mux = 32'(user_i_rate_q);
      lmr_pkg::OFS_USER_P_RATE: rd_mux = 32'(user_p_rate_q);
      lmr_pkg::OFS_CHG_RESERVE: rd_mux = 32'(chg_res_q);
      lmr_pkg::OFS_ENG_RESERVE: rd_mux = 32'(eng_res_q);
      lmr_pkg::OFS_QMAX_A: rd_mux = 32'(qmax_a_q);
      lmr_pkg::OFS_QMAX_B: rd_mux = 32'(qmax_b_q);
      lmr_pkg::OFS_LEARN_A: rd_mux = 32'(learn_a_q);
      lmr_pkg::OFS_LEARN_B: rd_mux = 32'(learn_b_q);
      lmr_pkg::OFS_RATE: rd_mux = {16'h0000, rate_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One wait-free access: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !rd_hit;
      if (setup && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Configuration writes; read-only words ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_mode_q <= lmr_pkg::RST_LOAD_MODE;
      load_sel_q <= lmr_pkg::RST_LOAD_SEL;
      dsg_thr_q <= lmr_pkg::RST_DSG_THR;
      chg_thr_q <= lmr_pkg::RST_CHG_THR;
      quit_cur_q <= lmr_pkg::RST_QUIT_CUR;
      dsg_relax_q <= lmr_pkg::RST_DSG_RELAX_S;
      chg_relax_q <= lmr_pkg::RST_CHG_RELAX_S;
      quit_relax_q <= lmr_pkg::RST_QUIT_RELAX_S;
      user_i_rate_q <= 16'h0000;
      user_p_rate_q <= 16'h0000;
      chg_res_q <= 16'h0000;
      eng_res_q <= 16'h0000;
    end else if (wr_en) begin
      unique case (a)
        lmr_pkg::OFS_CTRL: begin
          load_mode_q <= pwdata[lmr_pkg::CTRL_MODE_BIT];
          load_sel_q <= pwdata[lmr_pkg::CTRL_SEL_LSB +: lmr_pkg::SEL_W];
        end
        lmr_pkg::OFS_DSG_THR: dsg_thr_q <= pwdata[15:0];
        lmr_pkg::OFS_CHG_THR: chg_thr_q <= pwdata[15:0];
        lmr_pkg::OFS_QUIT_CUR: quit_cur_q <= pwdata[15:0];
        lmr_pkg::OFS_DSG_RELAX: dsg_relax_q <= pwdata[12:0];
        lmr_pkg::OFS_CHG_RELAX: chg_relax_q <= pwdata[7:0];
        lmr_pkg::OFS_QUIT_RELAX: quit_relax_q <= pwdata[5:0];
        lmr_pkg::OFS_USER_I_RATE: user_i_rate_q <= pwdata[15:0];
        lmr_pkg::OFS_USER_P_RATE: user_p_rate_q <= pwdata[15:0];
        lmr_pkg::OFS_CHG_RESERVE: chg_res_q <= pwdata[15:0];
        lmr_pkg::OFS_ENG_RESERVE: eng_res_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Whole-second tick shared by all timers and the low-pass filter
  wire logic pre_wrap = pre_q == PW'(SEC_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_wrap ? '0 : pre_q + 1'b1;
      tick_q <= pre_wrap;
    end
  end

  // First-order filter with a 14 s time constant, stepped once per second
  assign lpf_step = 17'((17'(filtered_average_current) - 17'(lpf_q)) / lmr_pkg::LPF_TAU_S);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpf_q <= 16'sh0000;
    end else if (tick_q) begin
      lpf_q <= 16'(17'(lpf_q) + lpf_step);
    end
  end

  // Flow detection; discharge current reads negative
  wire logic [15:0] i_mag = lmr_mag(sense_current);
  wire logic [15:0] avg_mag = lmr_mag(filtered_average_current);
  wire logic dsg_now = sense_current[15] && (i_mag > dsg_thr_q);
  wire logic chg_now = !sense_current[15] && (i_mag > chg_thr_q);
  wire logic quiet = avg_mag < quit_cur_q;
  wire logic loud = avg_mag > quit_cur_q;

  // Settle period follows the direction of the last real flow
  wire logic [12:0] entry_period = last_chg_q ? 13'(chg_relax_q) : dsg_relax_q;
  logic entry_done, exit_done;

  lmr_timer #(.W(13)) u_entry (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_q == lmr_pkg::LMR_ACTIVE && quiet),
    .tick(tick_q),
    .period(entry_period),
    .done(entry_done)
  );

  lmr_timer #(.W(6)) u_exit (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_q == lmr_pkg::LMR_RELAX && loud),
    .tick(tick_q),
    .period(quit_relax_q),
    .done(exit_done)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lmr_pkg::LMR_ACTIVE: if (entry_done) state_d = lmr_pkg::LMR_RELAX;
      lmr_pkg::LMR_RELAX: if (exit_done) state_d = lmr_pkg::LMR_ACTIVE;
    endcase
  end

  // Open-circuit readings wait for five unbroken relaxed minutes
  wire logic relax_now = state_q == lmr_pkg::LMR_RELAX;
  wire logic ocv_now = relax_now && relax_s_q >= lmr_pkg::OCV_WAIT_S;
  wire logic qok_now = ocv_now && voltage_slope_uv < lmr_pkg::SLOPE_LIMIT_UV;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= lmr_pkg::LMR_ACTIVE;
      last_chg_q <= 1'b0;
      relax_s_q <= 9'h000;
    end else begin
      state_q <= state_d;
      if (chg_now) begin
        last_chg_q <= 1'b1;
      end else if (dsg_now) begin
        last_chg_q <= 1'b0;
      end
      if (!relax_now) begin
        relax_s_q <= 9'h000;
      end else if (tick_q && relax_s_q < lmr_pkg::OCV_WAIT_S) begin
        relax_s_q <= relax_s_q + 9'h001;
      end
    end
  end

  // Learned capacity per profile; a hardware learn beats a software write
  wire logic learn_go = qmax_new_valid && qok_now;
  wire logic learn_a = learn_go && !qmax_new_profile;
  wire logic learn_b = learn_go && qmax_new_profile;

  assign qmax_a_d = learn_a ? qmax_new : wr_qmax_a ? pwdata[15:0] : qmax_a_q;
  assign qmax_b_d = learn_b ? qmax_new : wr_qmax_b ? pwdata[15:0] : qmax_b_q;

  always_comb begin
    learn_a_d = wr_learn_a ? pwdata[7:0] : learn_a_q;
    learn_b_d = wr_learn_b ? pwdata[7:0] : learn_b_q;
    if (learn_a) learn_a_d[lmr_pkg::LEARN_BIT] = 1'b1;
    if (learn_b) learn_b_d[lmr_pkg::LEARN_BIT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qmax_a_q <= lmr_pkg::RST_QMAX;
      qmax_b_q <= lmr_pkg::RST_QMAX;
      learn_a_q <= lmr_pkg::RST_LEARN;
      learn_b_q <= lmr_pkg::RST_LEARN;
    end else begin
      qmax_a_q <= qmax_a_d;
      qmax_b_q <= qmax_b_d;
      learn_a_q <= learn_a_d;
      learn_b_q <= learn_b_d;
    end
  end

  // Rate selection runs combinationally and is registered here
  lmr_rate_if rif ();
  assign rif.load_mode = load_mode_q;
  assign rif.load_select = load_sel_q;
  assign rif.avg_i_last = avg_i_last_run;
  assign rif.avg_i_now = avg_i_present;
  assign rif.avg_i_filt = filtered_average_current;
  assign rif.avg_i_lpf = lpf_q;
  assign rif.avg_p_last = avg_p_last_run;
  assign rif.avg_p_now = avg_p_present;
  assign rif.trial_rate = trial_rate_value;
  assign rif.cell_v = cell_voltage;
  assign rif.design_cap = design_capacity;
  assign rif.design_energy = design_energy;
  assign rif.user_i_rate = user_i_rate_q;
  assign rif.user_p_rate = user_p_rate_q;

  lmr_rate_sel u_rate (
    .rif(rif)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= 16'sh0000;
      dsg_q <= 1'b0;
      chg_q <= 1'b0;
      ocv_q <= 1'b0;
      qok_q <= 1'b0;
    end else begin
      rate_q <= rif.rate;
      dsg_q <= dsg_now;
      chg_q <= chg_now;
      ocv_q <= ocv_now;
      qok_q <= qok_now;
    end
  end

  // Reserves are not rate-scaled: they stand at their no-load value
  assign charge_reserve = chg_res_q;
  assign energy_reserve = eng_res_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign load_rate = rate_q;
  assign load_model_flag = load_mode_q;
  assign dsg_flowing = dsg_q;
  assign chg_flowing = chg_q;
  assign relax_active = state_q == lmr_pkg::LMR_RELAX;
  assign ocv_request = ocv_q;
  assign qmax_update_ok = qok_q;
endmodule // lmr_top

// ==== tb/lmr_top_monitor.sv ====
// Port-level property checker for the load model and relaxation control block
`timescale 1ns/1ps
module lmr_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lmr_pkg::ADDR_W-1:0] paddr,
  input wire logic [lmr_pkg::DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [15:0] sense_current,
  input wire logic [15:0] voltage_slope_uv,
  input wire logic load_model_flag,
  input wire logic dsg_flowing,
  input wire logic chg_flowing,
  input wire logic relax_active,
  input wire logic ocv_request,
  input wire logic qmax_update_ok
);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == lmr_pkg::OFS_CTRL;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_ready;
    pready ##1 !pready;
  endsequence
  property p_ready;
    s_setup |=> s_one_ready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_mode_set;
    ctrl_wr |=> load_model_flag == $past(pwdata[lmr_pkg::CTRL_MODE_BIT]);
  endproperty
  // Only a control write may move the flag, so a free-running flag is caught; a stuck one is left to p_mode_set
  property p_mode_hold;
    !ctrl_wr |=> $stable(load_model_flag);
  endproperty
  property p_dsg;
    dsg_flowing |-> $past(sense_current[15]);
  endproperty
  property p_chg;
    chg_flowing |-> !$past(sense_current[15]) && $past(sense_current) != 16'h0000;
  endproperty
  property p_ocv_rise;
    $rose(ocv_request) |-> relax_active && $past(relax_active);
  endproperty
  property p_ocv_drop;
    $fell(relax_active) |-> ##[0:1] !ocv_request;
  endproperty
  property p_qmax;
    qmax_update_ok |-> ocv_request && $past(voltage_slope_uv) < lmr_pkg::SLOPE_LIMIT_UV;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not single cycle after setup");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_mode_set: assert property (p_mode_set) else $error("load model flag not written");
  a_mode_hold: assert property (p_mode_hold) else $error("load model flag moved alone");
  a_dsg: assert property (p_dsg) else $error("discharge flag without discharge");
  a_chg: assert property (p_chg) else $error("charge flag without charge");
  a_ocv_rise: assert property (p_ocv_rise) else $error("ocv request outside relax");
  a_ocv_drop: assert property (p_ocv_drop) else $error("ocv request kept after relax");
  a_qmax: assert property (p_qmax) else $error("qmax update ok too early");
endmodule // lmr_top_monitor

bind lmr_top lmr_top_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .sense_current(sense_current), .voltage_slope_uv(voltage_slope_uv),
  .load_model_flag(load_model_flag), .dsg_flowing(dsg_flowing), .chg_flowing(chg_flowing),
  .relax_active(relax_active), .ocv_request(ocv_request), .qmax_update_ok(qmax_update_ok)
);

// ==== tb/tb_top.sv ====
// Self-checking bench for the load model and relaxation control block
`timescale 1ns/1ps
module tb_top;
  logic pclk, pready, pslverr, flag, dsg, chg, relax, ocv, qok;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic qvalid = 1'b0, qprof = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic signed [15:0] fac = 16'h0, sense = 16'h0, trial = 16'hff85, lr;
  logic signed [15:0] ail = 16'hfed4, aip = 16'hff06, apl = 16'hfb95, app = 16'hfc18;
  logic [15:0] dcap = 16'h07d0, deng = 16'h1ce8, cv = 16'h0e74, slope = 16'h0004;
  logic [15:0] qnew = 16'h0, cres, eres;
  int fail_count, compares, cyc;
  logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h30, 8'h34, 8'h38, 8'h3c, 8'h44};
  logic [31:0] rv [13] = '{32'h10, 32'h0, 32'h64, 32'h64, 32'h28, 32'h3c, 32'h3c, 32'h1,
    32'h3e8, 32'h3e8, 32'h0, 32'h0, 32'h0};
  // Select 2 and 3 expect zero here because the filtered current is held at zero
  logic [15:0] xr [2][7] = '{'{16'hfed4, 16'hff06, 16'h0, 16'h0, 16'h0190, 16'hff85, 16'h022b},
    '{16'hfb95, 16'hfc18, 16'h0, 16'h0, 16'h05c8, 16'hff85, 16'h0309}};
  logic [15:0] fs [6] = '{16'h0065, 16'h0064, 16'hff9c, 16'hff9b, 16'hfff6, 16'hfff5};
  logic [5:0] fd = 6'h28, fc = 6'h01;

  lmr_top #(.SEC_CYCLES(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filtered_average_current(fac), .sense_current(sense), .cell_voltage(cv),
    .avg_i_last_run(ail), .avg_i_present(aip), .avg_p_last_run(apl), .avg_p_present(app),
    .design_capacity(dcap), .design_energy(deng), .trial_rate_value(trial),
    .voltage_slope_uv(slope), .qmax_new(qnew), .qmax_new_valid(qvalid),
    .qmax_new_profile(qprof), .load_rate(lr), .load_model_flag(flag), .dsg_flowing(dsg),
    .chg_flowing(chg), .relax_active(relax), .ocv_request(ocv), .qmax_update_ok(qok),
    .charge_reserve(cres), .energy_reserve(eres));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; an idle cycle follows so psel is never driven twice in one step
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    chk("pslverr", {31'h0, a > 8'h40}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), e, r);
  endtask

  task automatic learn(logic p, logic [15:0] v);
    qprof <= p;
    qnew <= v;
    qvalid <= 1'b1;
    tick(1);
    qvalid <= 1'b0;
    tick(1);
  endtask

  initial begin
    tick(10);
    presetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
    wr(8'h20, 32'h022b);
    wr(8'h24, 32'h0309);
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 7; s++) begin
        wr(8'h00, {25'h0, 3'(s), 3'h0, 1'(m)});
        tick(1);
        chk("load_model_flag", 32'(m), {31'h0, flag});
        chk("load_rate", {16'h0, xr[m][s]}, {16'h0, lr});
      end
    end
    fac <= 16'hfe0c;
    wr(8'h00, 32'h20);
    tick(1);
    chk("load_rate", 32'hfe0c, {16'h0, lr});
    wr(8'h00, 32'h21);
    wr(8'h40, 32'h0);
    rd(8'h40, 32'hff47);
    wr(8'h28, 32'h1234);
    wr(8'h2c, 32'h5678);
    tick(1);
    chk("charge_reserve", 32'h1234, {16'h0, cres});
    chk("energy_reserve", 32'h5678, {16'h0, eres});
    for (int i = 0; i < 6; i++) begin
      if (i == 4) wr(8'h08, 32'h0a);
      sense <= fs[i];
      tick(2);
      chk("dsg_flowing", {31'h0, fd[i]}, {31'h0, dsg});
      chk("chg_flowing", {31'h0, fc[i]}, {31'h0, chg});
    end
    sense <= 16'h0;
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h3);
    wr(8'h1c, 32'h2);
    // Quiet spans stay under three whole seconds so only a missed restart can enter
    fac <= 16'hffe2;
    tick(35);
    fac <= 16'hfe0c;
    tick(5);
    fac <= 16'hffe2;
    tick(35);
    chk("relax_active", 32'h0, {31'h0, relax});
    for (int n = 0; n < 40 && relax !== 1'b1; n++) tick(1);
    chk("relax_active", 32'h1, {31'h0, relax});
    learn(1'b1, 16'h04d2);
    tick(5930);
    chk("ocv_request", 32'h0, {31'h0, ocv});
    for (int n = 0; n < 100 && ocv !== 1'b1; n++) tick(1);
    chk("ocv_request", 32'h1, {31'h0, ocv});
    chk("qmax_update_ok", 32'h0, {31'h0, qok});
    rd(8'h34, 32'h3e8);
    slope <= 16'h0003;
    tick(2);
    chk("qmax_update_ok", 32'h1, {31'h0, qok});
    learn(1'b1, 16'h04d2);
    rd(8'h34, 32'h04d2);
    rd(8'h3c, 32'h1);
    rd(8'h30, 32'h3e8);
    rd(8'h38, 32'h0);
    learn(1'b0, 16'h03e7);
    rd(8'h30, 32'h03e7);
    rd(8'h38, 32'h1);
    wr(8'h38, 32'h0);
    rd(8'h38, 32'h0);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h39);
    // After minutes at -30 the 14 s filter has climbed from below and stalls at -43
    wr(8'h00, 32'h30);
    tick(1);
    chk("load_rate", 32'hffd5, {16'h0, lr});
    wr(8'h00, 32'h31);
    tick(1);
    chk("load_rate", 32'hfff1, {16'h0, lr});
    fac <= 16'hfe0c;
    tick(15);
    fac <= 16'hffe2;
    tick(5);
    fac <= 16'hfe0c;
    tick(15);
    chk("relax_active", 32'h1, {31'h0, relax});
    for (int n = 0; n < 40 && relax !== 1'b0; n++) tick(1);
    chk("relax_active", 32'h0, {31'h0, relax});
    tick(2);
    chk("ocv_request", 32'h0, {31'h0, ocv});
    wr(8'h44, 32'h1);
    report_and_stop();
  end
endmodule // tb_top
